// file: src/aifc_pkg.sv
// Package of offsets, field positions and reset values for the flag block
`default_nettype none
package aifc_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_FLAG = 8'h38;   // Raw flag view
   localparam logic [7:0] OFS_SET = 8'h3C;
   localparam logic [7:0] OFS_CLEAR = 8'h40;
   localparam logic [7:0] OFS_ENABLE = 8'h44;
   localparam logic [7:0] OFS_CONFIG = 8'h60; // Read-clear option
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h64;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h68;
   localparam logic [7:0] OFS_WATERMARK = 8'h6C;
   // ---------------------------------------------------------------
   // Flag bit positions
   // ---------------------------------------------------------------
   localparam int BIT_ONESHOT_DONE = 0;
   localparam int BIT_SEQUENCE_DONE = 1;
   localparam int BIT_ONESHOT_OVF = 8;
   localparam int BIT_SEQUENCE_OVF = 9;
   localparam int BIT_ONESHOT_UNF = 10;
   localparam int BIT_SEQUENCE_UNF = 11;
   localparam int BIT_ONESHOT_CMP = 16;
   localparam int BIT_SEQUENCE_CMP = 17;
   localparam int BIT_REF_OVERVOLT = 24;
   localparam int BIT_PROG_FAULT = 25;
   localparam logic [31:0] FLAG_MASK = 32'h0303_0F03;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Sizes and bus answers
   // ---------------------------------------------------------------
   localparam int LEVEL_W = 3;   // FIFO fill level width
   localparam int WM_W = 2;      // Watermark field width
   localparam int WM_SEQ_LSB = 16; // Sequence watermark field start
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] UNDEF_READ = 32'h0000_0000;
endpackage : aifc_pkg
`default_nettype wire

// file: src/aifc_fifo_events.sv
// Per-FIFO event detector: completion, overflow and underflow pulses
`default_nettype none
module aifc_fifo_events (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [aifc_pkg::LEVEL_W-1:0] fill_level,
   input wire logic fifo_full,
   input wire logic result_push,
   input wire logic result_pop,
   input wire logic [aifc_pkg::WM_W-1:0] fifo_watermark_level,
   output logic done_pulse,
   output logic overflow_pulse,
   output logic underflow_pulse
);
   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic above_wm;
   logic above_wm_reg;
   logic [aifc_pkg::LEVEL_W-1:0] wm_plus_one;
   // Level threshold is watermark plus one results
   assign wm_plus_one = aifc_pkg::LEVEL_W'({1'b0, fifo_watermark_level})
      + aifc_pkg::LEVEL_W'(1);
   assign above_wm = (fill_level >= wm_plus_one);
   // Rising edge so the flag fires once per crossing, not every cycle
   assign done_pulse = above_wm & ~above_wm_reg;
   // Push with no free entry loses a result
   assign overflow_pulse = result_push & fifo_full;
   // Pop while empty returns no data
   assign underflow_pulse = result_pop
      & (fill_level == aifc_pkg::LEVEL_W'(0));
   // Track previous threshold state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         above_wm_reg <= 1'b0;
      end else begin
         above_wm_reg <= above_wm;
      end
   end
endmodule : aifc_fifo_events
`default_nettype wire

// file: src/aifc_top.sv
// Flag set, clear and enable logic for an ADC peripheral, AXI4-Lite slave
//
// Contract
// - One-shot done flag (bit 0) rises when its FIFO holds watermark+1.
// - Writing ones to the clear register clears those flags, zeros do not.
// - With read-clear on, reading clear register returns and clears flags.
// - Each enable bit lets its flag drive the request; reset to zero.
// - The one-shot compare enable at bit 16 is separate from bit 17.
// - Overflow flag rises when a result arrives and the FIFO is full.
// - Underflow flag rises when software reads an empty FIFO.
//
// Implementation choice: register access over AXI4-Lite.
`default_nettype none
module aifc_top (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Datapath events, same clock
   input wire logic [aifc_pkg::LEVEL_W-1:0] oneshot_level,
   input wire logic oneshot_full,
   input wire logic oneshot_push,
   input wire logic oneshot_pop,
   input wire logic [aifc_pkg::LEVEL_W-1:0] sequence_level,
   input wire logic sequence_full,
   input wire logic sequence_push,
   input wire logic sequence_pop,
   input wire logic oneshot_compare_match,
   input wire logic sequence_compare_match,
   input wire logic reference_overvoltage,
   input wire logic programming_fault,
   // Outputs
   output logic adc_irq,
   output logic sys_irq
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [31:0] flag_reg;
   logic [31:0] flag_next;
   logic [31:0] enable_reg;
   logic [31:0] enable_next;
   logic read_clear_reg;
   logic [aifc_pkg::WM_W-1:0] wm_oneshot_reg;
   logic [aifc_pkg::WM_W-1:0] wm_sequence_reg;
   logic [3:0] ev_status_reg;
   logic [3:0] ev_status_next;
   logic [3:0] ev_mask_reg;
   // Address and data of a write are held until both halves have arrived
   logic aw_held_reg;
   logic [7:0] aw_addr_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;

   // ---------------------------------------------------------------
   // Event detection per FIFO
   // ---------------------------------------------------------------
   // One detector per FIFO; the two differ only in their wiring
   logic os_done, os_ovf, os_unf;
   logic sq_done, sq_ovf, sq_unf;

   aifc_fifo_events u_oneshot (
      .aclk(aclk),
      .aresetn(aresetn),
      .fill_level(oneshot_level),
      .fifo_full(oneshot_full),
      .result_push(oneshot_push),
      .result_pop(oneshot_pop),
      .fifo_watermark_level(wm_oneshot_reg),
      .done_pulse(os_done),
      .overflow_pulse(os_ovf),
      .underflow_pulse(os_unf)
   );

   aifc_fifo_events u_sequence (
      .aclk(aclk),
      .aresetn(aresetn),
      .fill_level(sequence_level),
      .fifo_full(sequence_full),
      .result_push(sequence_push),
      .result_pop(sequence_pop),
      .fifo_watermark_level(wm_sequence_reg),
      .done_pulse(sq_done),
      .overflow_pulse(sq_ovf),
      .underflow_pulse(sq_unf)
   );

   // ---------------------------------------------------------------
   // Hardware flag sources gathered into the raw flag layout
   // ---------------------------------------------------------------
   // Level sources re-set their flag every cycle they stay high, so a
   // clear only sticks once the source itself has gone away
   logic [31:0] hw_set;
   always_comb begin
      hw_set = aifc_pkg::RESET_ZERO;
      hw_set[aifc_pkg::BIT_ONESHOT_DONE] = os_done;
      hw_set[aifc_pkg::BIT_SEQUENCE_DONE] = sq_done;
      hw_set[aifc_pkg::BIT_ONESHOT_OVF] = os_ovf;
      hw_set[aifc_pkg::BIT_SEQUENCE_OVF] = sq_ovf;
      hw_set[aifc_pkg::BIT_ONESHOT_UNF] = os_unf;
      hw_set[aifc_pkg::BIT_SEQUENCE_UNF] = sq_unf;
      hw_set[aifc_pkg::BIT_ONESHOT_CMP] = oneshot_compare_match;
      hw_set[aifc_pkg::BIT_SEQUENCE_CMP] = sequence_compare_match;
      hw_set[aifc_pkg::BIT_REF_OVERVOLT] = reference_overvoltage;
      hw_set[aifc_pkg::BIT_PROG_FAULT] = programming_fault;
   end

   // ---------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ---------------------------------------------------------------
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   wire [31:0] wr_bmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [31:0] wr_val = w_data_reg & wr_bmask;
   wire wr_set = wr_fire & (aw_addr_reg == aifc_pkg::OFS_SET);
   wire wr_clear = wr_fire & (aw_addr_reg == aifc_pkg::OFS_CLEAR);
   wire wr_enable = wr_fire & (aw_addr_reg == aifc_pkg::OFS_ENABLE);
   wire wr_config = wr_fire & (aw_addr_reg == aifc_pkg::OFS_CONFIG);
   wire wr_mask = wr_fire & (aw_addr_reg == aifc_pkg::OFS_IRQ_MASK);
   wire wr_wm = wr_fire & (aw_addr_reg == aifc_pkg::OFS_WATERMARK);
   wire wr_known = wr_set | wr_clear | wr_enable | wr_config
      | wr_mask | wr_wm;

   // ---------------------------------------------------------------
   // Read channel: one cycle after the address is taken
   // ---------------------------------------------------------------
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire rd_flag = (s_axi_araddr == aifc_pkg::OFS_FLAG);
   wire rd_set = (s_axi_araddr == aifc_pkg::OFS_SET);
   wire rd_clear = (s_axi_araddr == aifc_pkg::OFS_CLEAR);
   wire rd_enable = (s_axi_araddr == aifc_pkg::OFS_ENABLE);
   wire rd_config = (s_axi_araddr == aifc_pkg::OFS_CONFIG);
   wire rd_status = (s_axi_araddr == aifc_pkg::OFS_IRQ_STATUS);
   wire rd_mask = (s_axi_araddr == aifc_pkg::OFS_IRQ_MASK);
   wire rd_wm = (s_axi_araddr == aifc_pkg::OFS_WATERMARK);
   wire rd_known = rd_flag | rd_set | rd_clear | rd_enable | rd_config
      | rd_status | rd_mask | rd_wm;
   // Decodes use the live read address: the master holds it until taken
   // Without read-clear the clear port is write-only; undefined reads zero
   wire [31:0] rd_data =
      (rd_flag ? flag_reg : 32'h0000_0000)
      | (rd_set ? aifc_pkg::UNDEF_READ : 32'h0000_0000)
      | ((rd_clear & read_clear_reg) ? flag_reg : 32'h0000_0000)
      | (rd_enable ? enable_reg : 32'h0000_0000)
      | (rd_config ? {31'h0000_0000, read_clear_reg} : 32'h0000_0000)
      | (rd_status ? {28'h000_0000, ev_status_reg} : 32'h0000_0000)
      | (rd_mask ? {28'h000_0000, ev_mask_reg} : 32'h0000_0000)
      | (rd_wm ? {14'h0000, wm_sequence_reg, 14'h0000, wm_oneshot_reg}
         : 32'h0000_0000);
   // Read-clear removes exactly the bits being returned
   wire [31:0] rd_clr_bits = (ar_take & rd_clear & read_clear_reg)
      ? flag_reg : 32'h0000_0000;

   // ---------------------------------------------------------------
   // Raw flag update: hardware set wins over any clear
   // ---------------------------------------------------------------
   // Set wins so a hardware event in the clearing cycle is never lost
   wire [31:0] sw_set = wr_set ? wr_val : 32'h0000_0000;
   wire [31:0] sw_clr = wr_clear ? wr_val : 32'h0000_0000;
   // Zeros in the clear word leave flags alone; unused bits never stick
   assign flag_next = ((flag_reg & ~sw_clr & ~rd_clr_bits)
      | sw_set | hw_set) & aifc_pkg::FLAG_MASK;
   // Unused enable bits are kept at zero whatever is written
   assign enable_next = wr_enable
      ? (enable_reg & ~wr_bmask) | (wr_val & aifc_pkg::FLAG_MASK)
      : enable_reg;

   // ---------------------------------------------------------------
   // Sticky event status: bus write error, bus read error,
   // irq rising, read-clear used. Cleared by reading it.
   // ---------------------------------------------------------------
   // Next request level; its rise is logged at the edge that raises
   // adc_irq, since the registered output always trails by one step
   wire irq_next = |(flag_next & enable_next);
   wire [3:0] ev_in = {ar_take & rd_clear & read_clear_reg,
      irq_next & ~adc_irq, ar_take & ~rd_known, wr_fire & ~wr_known};
   // Reading status clears it; an event in that same cycle survives
   wire st_rclr = ar_take & rd_status;
   assign ev_status_next = (st_rclr ? 4'h0 : ev_status_reg) | ev_in;

   // Flag, enable and event registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= aifc_pkg::RESET_ZERO;
         enable_reg <= aifc_pkg::RESET_ZERO;
         ev_status_reg <= 4'h0;
      end else begin
         flag_reg <= flag_next;
         enable_reg <= enable_next;
         ev_status_reg <= ev_status_next;
      end
   end

   // Configuration registers
   // Byte lanes are honoured per field, so a partial write keeps the rest
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_clear_reg <= 1'b0;
         ev_mask_reg <= 4'h0;
         wm_oneshot_reg <= '0;
         wm_sequence_reg <= '0;
      end else begin
         if (wr_config & w_strb_reg[0]) read_clear_reg <= w_data_reg[0];
         if (wr_mask & w_strb_reg[0]) ev_mask_reg <= w_data_reg[3:0];
         if (wr_wm & w_strb_reg[0])
            wm_oneshot_reg <= w_data_reg[aifc_pkg::WM_W-1:0];
         if (wr_wm & w_strb_reg[2])
            wm_sequence_reg <= w_data_reg[aifc_pkg::WM_SEQ_LSB
               +: aifc_pkg::WM_W];
      end
   end

   // Interrupt outputs, each from a flip-flop
   // Both are levels: software must remove the cause to drop them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adc_irq <= 1'b0;
         sys_irq <= 1'b0;
      end else begin
         adc_irq <= irq_next;
         sys_irq <= |(ev_status_next & ev_mask_reg);
      end
   end

   // Write address and data holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_fire) aw_held_reg <= 1'b0;
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_fire) w_held_reg <= 1'b0;
      end
   end

   // Write ready and response; ready drops once a beat is held
   // Limitation: one write at a time, the next waits for the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= aifc_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_held_reg & ~aw_take & ~s_axi_bvalid;
         s_axi_wready <= ~w_held_reg & ~w_take & ~s_axi_bvalid;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? aifc_pkg::RESP_OKAY
               : aifc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      end
   end

   // Read ready and data
   // Data is latched at the address edge and stands until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= aifc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_known ? aifc_pkg::RESP_OKAY
               : aifc_pkg::RESP_SLVERR;
         end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end
endmodule : aifc_top
`default_nettype wire

// file: sim/aifc_chk.sv
// Checker of bus timing and interrupt causes for the flag block
`default_nettype none
module aifc_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [aifc_pkg::LEVEL_W-1:0] oneshot_level,
   input wire logic oneshot_push,
   input wire logic oneshot_pop,
   input wire logic [aifc_pkg::LEVEL_W-1:0] sequence_level,
   input wire logic sequence_push,
   input wire logic sequence_pop,
   input wire logic oneshot_compare_match,
   input wire logic sequence_compare_match,
   input wire logic reference_overvoltage,
   input wire logic programming_fault,
   input wire logic adc_irq,
   input wire logic sys_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [aifc_pkg::LEVEL_W-1:0] os_q;
   logic [aifc_pkg::LEVEL_W-1:0] sq_q;
   logic ev_any;
   // Last levels, so a watermark crossing also counts as a cause
   always_ff @(posedge aclk) begin
      os_q <= oneshot_level;
      sq_q <= sequence_level;
   end
   assign ev_any = oneshot_push | oneshot_pop | sequence_push | sequence_pop
      | oneshot_compare_match | sequence_compare_match | programming_fault
      | reference_overvoltage | (oneshot_level != os_q)
      | (sequence_level != sq_q);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer not two cycles after take");
   a_aw_refused: assert property (s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready [*2]) else $error("write address taken again");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open during answer");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   // Request may only rise after an event or a register write
   a_irq_has_cause: assert property ($rose(adc_irq) |->
      $rose(s_axi_bvalid) || $past(ev_any) || $past(ev_any, 2))
      else $error("interrupt rose without cause");
   a_irq_drop_cause: assert property ($fell(adc_irq) |->
      $rose(s_axi_bvalid) || $past(s_axi_arvalid && s_axi_arready))
      else $error("interrupt fell without write or read");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_irq_rise: cover property ($rose(adc_irq));
   c_irq_fall: cover property ($fell(adc_irq));
   c_sys_irq: cover property ($rose(sys_irq));
endmodule : aifc_chk
bind aifc_top aifc_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .oneshot_level, .oneshot_push, .oneshot_pop,
   .sequence_level, .sequence_push, .sequence_pop, .oneshot_compare_match,
   .sequence_compare_match, .reference_overvoltage, .programming_fault,
   .adc_irq, .sys_irq);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the ADC flag set, clear and enable block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_FLG = aifc_pkg::OFS_FLAG;
   localparam logic [7:0] A_SET = aifc_pkg::OFS_SET;
   localparam logic [7:0] A_CLR = aifc_pkg::OFS_CLEAR;
   localparam logic [7:0] A_EN = aifc_pkg::OFS_ENABLE;
   localparam logic [7:0] A_STS = aifc_pkg::OFS_IRQ_STATUS;
   localparam logic [1:0] OK = aifc_pkg::RESP_OKAY;
   localparam logic [1:0] ER = aifc_pkg::RESP_SLVERR;
   localparam logic [31:0] ALL = aifc_pkg::FLAG_MASK;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, adc_irq, sys_irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, ev;
   logic [31:0] s_axi_wdata, s_axi_rdata, v, c;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [aifc_pkg::LEVEL_W-1:0] os_lvl, sq_lvl;
   logic [33:0] q[$];
   logic [1:0] bq[$];
   logic [33:0] e;
   int n_mismatch, comparisons;
   int eb[8] = '{8, 9, 10, 11, 16, 17, 24, 25};
   // Full and push share one line: a push only counts into a full FIFO
   aifc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oneshot_level(os_lvl),
      .oneshot_full(ev[0]), .oneshot_push(ev[0]), .oneshot_pop(ev[2]),
      .sequence_level(sq_lvl), .sequence_full(ev[1]),
      .sequence_push(ev[1]), .sequence_pop(ev[3]),
      .oneshot_compare_match(ev[4]), .sequence_compare_match(ev[5]),
      .reference_overvoltage(ev[6]), .programming_fault(ev[7]),
      .adc_irq, .sys_irq);
   // ------------------------------------------------------------
   // Clock, shared tasks and read monitor
   // ------------------------------------------------------------
   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   task to_err;
      n_mismatch++;
      $display("ERROR %0t wait timed out", $time);
      stop_test();
   endtask : to_err
   task ck(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, g, x);
      end
   endtask : ck
   // Response ready is raised late so the held answer is exercised
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
      int n;
      n = 0;
      bq.push_back(rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (n > 50) to_err();
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h1;
      @(posedge aclk);
      s_axi_bready <= 1'h0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
      int n;
      n = 0;
      q.push_back({rs, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (n > 50) to_err();
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h1;
      @(posedge aclk);
      s_axi_rready <= 1'h0;
   endtask : rd
   task irq(input logic [1:0] x);
      repeat (2) @(posedge aclk);
      ck({30'h0, adc_irq, sys_irq}, {30'h0, x});
   endtask : irq
   task pulse(input int k);
      @(posedge aclk);
      ev <= 8'h01 << k;
      @(posedge aclk);
      ev <= 8'h00;
   endtask : pulse
   // Read data is judged against the oldest note; error reads skip data
   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
         comparisons++;
         if (s_axi_bresp !== bq.pop_front()) begin
            n_mismatch++;
            $display("ERROR %0t write response %h", $time, s_axi_bresp);
         end
      end
      if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
         e = q.pop_front();
         comparisons++;
         if (s_axi_rresp !== e[33:32]
            || (e[33:32] == OK && s_axi_rdata !== e[31:0])) begin
            n_mismatch++;
            $display("ERROR %0t read %h expected %h", $time, s_axi_rdata,
               e[31:0]);
         end
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev, os_lvl,
         sq_lvl} <= '0;
      s_axi_wstrb <= 4'hF;
      v = 32'h0000_000F;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      rd(A_EN, 32'h0, OK);
      v = lfsr(v);
      c = lfsr(v);
      wr(A_SET, v & ALL, OK);
      rd(A_FLG, v & ALL, OK);
      rd(A_SET, aifc_pkg::UNDEF_READ, OK);
      wr(A_SET, ALL, OK);
      wr(A_CLR, c & ALL, OK);
      rd(A_FLG, ~c & ALL, OK);
      wr(A_CLR, ALL, OK);
      $display("test set and clear done");
      wr(A_EN, 32'h0001_0000, OK);
      rd(A_EN, 32'h0001_0000, OK);
      wr(A_SET, 32'h0002_0000, OK);
      irq(2'h0);
      wr(A_SET, 32'h0001_0000, OK);
      irq(2'h2);
      wr(A_CLR, ALL, OK);
      irq(2'h0);
      $display("test enable done");
      wr(A_EN, ALL, OK);
      foreach (eb[k]) begin
         pulse(k);
         rd(A_FLG, 32'h1 << eb[k], OK);
         irq(2'h2);
         wr(A_CLR, 32'h1 << eb[k], OK);
         irq(2'h0);
      end
      $display("test events done");
      // Watermark two: the flag waits for the third result
      wr(aifc_pkg::OFS_WATERMARK, 32'h2, OK);
      for (int k = 1; k < 4; k++) begin
         @(posedge aclk);
         os_lvl <= k[2:0];
         rd(A_FLG, (k == 3) ? 32'h1 : 32'h0, OK);
      end
      @(posedge aclk);
      sq_lvl <= 3'h1;
      rd(A_FLG, 32'h3, OK);
      wr(A_CLR, ALL, OK);
      $display("test watermark done");
      wr(aifc_pkg::OFS_CONFIG, 32'h1, OK);
      v = lfsr(v);
      wr(A_SET, v & ALL, OK);
      rd(A_CLR, v & ALL, OK);
      rd(A_FLG, 32'h0, OK);
      irq(2'h0);
      wr(aifc_pkg::OFS_CONFIG, 32'h0, OK);
      $display("test read clear done");
      rd(A_STS, 32'hC, OK);
      rd(A_STS, 32'h0, OK);
      wr(aifc_pkg::OFS_IRQ_MASK, 32'h2, OK);
      rd(8'hF0, 32'h0, ER);
      irq(2'h1);
      rd(A_STS, 32'h2, OK);
      irq(2'h0);
      wr(8'hF4, 32'h1, ER);
      irq(2'h0);
      rd(A_STS, 32'h1, OK);
      $display("test event status done");
      stop_test();
   end
endmodule : tb
`default_nettype wire
